// ### include/byte_alu_pkg.sv
// constants, register map and operation codes for the byte alu slice
package byte_alu_pkg;

    // register byte offsets, one aligned word each
    localparam logic [7:0] acc_offset    = 8'h00;
    localparam logic [7:0] freg_offset   = 8'h04;
    localparam logic [7:0] status_offset = 8'h08;
    localparam logic [7:0] cmd_offset    = 8'h0c;
    localparam logic [7:0] dir_offset    = 8'h10;
    localparam logic [7:0] result_offset = 8'h14;

    // status register fields
    localparam int carry_bit      = 0;
    localparam int half_carry_bit = 1;
    localparam int zero_bit       = 2;

    // command register fields
    localparam int op_lsb    = 0;
    localparam int dest_bit  = 3;
    localparam int faddr_lsb = 8;
    localparam int lit_lsb   = 16;

    // destination select and the only legal direction register select
    localparam logic       dest_acc    = 1'b0;
    localparam logic       dest_file   = 1'b1;
    localparam logic [4:0] dir_sel_ok  = 5'h06;

    // reset values
    localparam logic [7:0]  acc_reset    = 8'h00;
    localparam logic [7:0]  freg_reset   = 8'h00;
    localparam logic [2:0]  flags_reset  = 3'h0;
    localparam logic [7:0]  dir_reset    = 8'hff;
    localparam logic [23:0] cmd_reset    = 24'h000000;
    localparam logic [7:0]  result_reset = 8'h00;

    // ahb encodings
    localparam logic [1:0] htrans_nonseq = 2'h2;
    localparam logic       hresp_okay    = 1'b0;

    typedef enum logic [2:0] {
        op_none                 = 3'h0,
        op_sub_acc_from_reg     = 3'h1,
        op_rotate_left_thru_carry  = 3'h2,
        op_rotate_right_thru_carry = 3'h3,
        op_nibble_exchange      = 3'h4,
        op_port_direction_load  = 3'h5,
        op_xor_acc_immediate    = 3'h6,
        op_xor_acc_with_reg     = 3'h7
    } alu_op_type;

endpackage : byte_alu_pkg

// ### verilog/byte_alu.sv
// byte alu slice with ahb-lite register access
`timescale 1ns/1ps

// Notes on behaviour
// - subtract gives file value minus accumulator, to destination, updating carry, half carry, zero.
// - destination bit 0 sends result to accumulator, 1 back to file register.
// - rotate right through carry: old carry into bit 7, bit 0 to carry.
// - rotate left through carry: old carry into bit 0, bit 7 to carry.
// - nibble exchange swaps the two halves of the file value, flags untouched.
// - direction load copies accumulator to direction register when select is 6, no flags.
// - immediate xor: accumulator xor literal back into accumulator, only Z changes.
// - register xor: accumulator xor file value to destination, only Z changes.
module byte_alu
    import byte_alu_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // datapath state
    output logic      [7:0]  acc_out,
    output logic      [7:0]  freg_out,
    output logic      [7:0]  dir_out,
    output logic             carry_out,
    output logic             half_carry_out,
    output logic             zero_out
);
    import byte_alu_pkg::*;

    // bus state
    logic        wr_pend_r, wr_pend_nxt;
    logic [7:0]  waddr_r, waddr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic        hreadyout_r;

    // datapath state
    logic [7:0]  acc_r, acc_nxt;
    logic [7:0]  freg_r, freg_nxt;
    logic [7:0]  dir_r, dir_nxt;
    logic [7:0]  result_r, result_nxt;
    logic [2:0]  flags_r, flags_nxt;
    logic [23:0] cmd_r, cmd_nxt;

    // decoded command in its data phase
    logic        cmd_go;
    alu_op_type  op;
    logic        dest;
    logic [4:0]  faddr;
    logic [7:0]  lit;
    logic [8:0]  diff;
    logic [4:0]  diff_lo;
    logic [7:0]  res;
    logic [2:0]  res_flags;
    logic        res_valid;
    logic        addr_phase;

    assign addr_phase = hsel && htrans == htrans_nonseq && hready;
    assign cmd_go     = wr_pend_r && waddr_r == cmd_offset;
    assign op         = alu_op_type'(hwdata[op_lsb +: 3]);
    assign dest       = hwdata[dest_bit];
    assign faddr      = hwdata[faddr_lsb +: 5];
    assign lit        = hwdata[lit_lsb +: 8];
    // the borrow bits come out inverted, as carry means no borrow
    assign diff       = {1'b0, freg_r} - {1'b0, acc_r};
    assign diff_lo    = {1'b0, freg_r[3:0]} - {1'b0, acc_r[3:0]};

    // operation result and flags, before destination routing
    always_comb begin
        res       = freg_r;
        res_flags = flags_r;
        res_valid = 1'b1;
        case (op)
            op_sub_acc_from_reg: begin
                res                       = diff[7:0];
                res_flags[carry_bit]      = ~diff[8];
                res_flags[half_carry_bit] = ~diff_lo[4];
                res_flags[zero_bit]       = (diff[7:0] == 8'h00);
            end
            op_rotate_right_thru_carry: begin
                res                  = {flags_r[carry_bit], freg_r[7:1]};
                res_flags[carry_bit] = freg_r[0];
            end
            op_rotate_left_thru_carry: begin
                res                  = {freg_r[6:0], flags_r[carry_bit]};
                res_flags[carry_bit] = freg_r[7];
            end
            op_nibble_exchange: begin
                res = {freg_r[3:0], freg_r[7:4]};
            end
            op_xor_acc_immediate: begin
                res                 = acc_r ^ lit;
                res_flags[zero_bit] = ((acc_r ^ lit) == 8'h00);
            end
            op_xor_acc_with_reg: begin
                res                 = acc_r ^ freg_r;
                res_flags[zero_bit] = ((acc_r ^ freg_r) == 8'h00);
            end
            default: begin
                res_valid = 1'b0;
            end
        endcase
    end

    // next register values: software writes or command execution
    always_comb begin
        acc_nxt    = acc_r;
        freg_nxt   = freg_r;
        dir_nxt    = dir_r;
        result_nxt = result_r;
        flags_nxt  = flags_r;
        cmd_nxt    = cmd_r;
        if (wr_pend_r) begin
            case (waddr_r)
                acc_offset:    acc_nxt   = hwdata[7:0];
                freg_offset:   freg_nxt  = hwdata[7:0];
                status_offset: flags_nxt = hwdata[2:0];
                default:       acc_nxt   = acc_r;
            endcase
        end
        if (cmd_go) begin
            cmd_nxt = hwdata[23:0];
            if (op == op_port_direction_load) begin
                // an illegal select is dropped rather than aliased onto the port
                if (faddr == dir_sel_ok) begin
                    dir_nxt = acc_r;
                end
            end else if (res_valid) begin
                result_nxt = res;
                flags_nxt  = res_flags;
                // the literal form has no destination bit and always lands in acc
                if (op == op_xor_acc_immediate || dest == dest_acc) begin
                    acc_nxt = res;
                end else begin
                    freg_nxt = res;
                end
            end
        end
    end

    // read data built from next values so a write then read returns fresh data
    always_comb begin
        wr_pend_nxt = addr_phase && hwrite;
        waddr_nxt   = haddr[7:0];
        hrdata_nxt  = 32'h00000000;
        if (addr_phase && !hwrite) begin
            case (haddr[7:0])
                acc_offset:    hrdata_nxt = {24'h000000, acc_nxt};
                freg_offset:   hrdata_nxt = {24'h000000, freg_nxt};
                status_offset: hrdata_nxt = {29'h00000000, flags_nxt};
                cmd_offset:    hrdata_nxt = {8'h00, cmd_nxt};
                dir_offset:    hrdata_nxt = {24'h000000, dir_nxt};
                result_offset: hrdata_nxt = {24'h000000, result_nxt};
                default:       hrdata_nxt = 32'h00000000;
            endcase
        end
    end

    // zero wait states: ready rises at the first edge out of reset and stays
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r   <= 1'b0;
            waddr_r     <= 8'h00;
            hrdata_r    <= 32'h00000000;
            hreadyout_r <= 1'b0;
            acc_r       <= acc_reset;
            freg_r      <= freg_reset;
            dir_r       <= dir_reset;
            result_r    <= result_reset;
            flags_r     <= flags_reset;
            cmd_r       <= cmd_reset;
        end else begin
            wr_pend_r   <= wr_pend_nxt;
            waddr_r     <= waddr_nxt;
            hrdata_r    <= hrdata_nxt;
            hreadyout_r <= 1'b1;
            acc_r       <= acc_nxt;
            freg_r      <= freg_nxt;
            dir_r       <= dir_nxt;
            result_r    <= result_nxt;
            flags_r     <= flags_nxt;
            cmd_r       <= cmd_nxt;
        end
    end

    assign hrdata         = hrdata_r;
    assign hreadyout      = hreadyout_r;
    assign hresp          = hresp_okay;
    assign acc_out        = acc_r;
    assign freg_out       = freg_r;
    assign dir_out        = dir_r;
    assign carry_out      = flags_r[carry_bit];
    assign half_carry_out = flags_r[half_carry_bit];
    assign zero_out       = flags_r[zero_bit];

    // checks
    a_sub_to_acc: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_sub_acc_from_reg && dest == dest_acc
        |=> acc_r == $past(freg_r) - $past(acc_r) && freg_r == $past(freg_r))
        else $error("subtract to accumulator wrong");

    a_sub_borrow_flags: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_sub_acc_from_reg
        |=> carry_out == ($past(freg_r) >= $past(acc_r))
            && half_carry_out == ($past(freg_r[3:0]) >= $past(acc_r[3:0])))
        else $error("subtract carry or half carry wrong");

    a_dest_file_write: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && dest == dest_file && op inside {op_sub_acc_from_reg, op_xor_acc_with_reg,
            op_nibble_exchange, op_rotate_left_thru_carry, op_rotate_right_thru_carry}
        |=> acc_r == $past(acc_r) && freg_r == result_r)
        else $error("file destination not honoured");

    a_rotate_right: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_rotate_right_thru_carry
        |=> result_r == {$past(carry_out), $past(freg_r[7:1])} && carry_out == $past(freg_r[0])
            && zero_out == $past(zero_out) && half_carry_out == $past(half_carry_out))
        else $error("rotate right wrong");

    a_rotate_left: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_rotate_left_thru_carry
        |=> result_r == {$past(freg_r[6:0]), $past(carry_out)} && carry_out == $past(freg_r[7])
            && zero_out == $past(zero_out))
        else $error("rotate left wrong");

    a_swap_nibbles: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_nibble_exchange
        |=> result_r == {$past(freg_r[3:0]), $past(freg_r[7:4])} && $stable(flags_r))
        else $error("nibble exchange wrong");

    a_dir_load: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_port_direction_load
        |=> dir_r == ($past(faddr) == dir_sel_ok ? $past(acc_r) : $past(dir_r)) && $stable(flags_r))
        else $error("direction load wrong");

    a_xor_immediate: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_xor_acc_immediate
        |=> acc_r == ($past(acc_r) ^ $past(lit)) && carry_out == $past(carry_out)
            && zero_out == (acc_r == 8'h00))
        else $error("immediate xor wrong");

    a_xor_register: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_xor_acc_with_reg
        |=> result_r == ($past(acc_r) ^ $past(freg_r)) && half_carry_out == $past(half_carry_out)
            && zero_out == (result_r == 8'h00))
        else $error("register xor wrong");

    a_sub_zero_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_sub_acc_from_reg
        |=> zero_out == ($past(freg_r) == $past(acc_r)))
        else $error("subtract zero flag wrong");

    a_dest_acc_write: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && dest == dest_acc && op inside {op_sub_acc_from_reg, op_xor_acc_with_reg,
            op_nibble_exchange, op_rotate_left_thru_carry, op_rotate_right_thru_carry}
        |=> freg_r == $past(freg_r) && acc_r == result_r)
        else $error("accumulator destination not honoured");

    a_xor_imm_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_xor_acc_immediate
        |=> freg_r == $past(freg_r) && half_carry_out == $past(half_carry_out) && result_r == acc_r)
        else $error("immediate xor touched more than accumulator and zero");

    a_xor_reg_carry: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_xor_acc_with_reg
        |=> carry_out == $past(carry_out))
        else $error("register xor changed carry");

    a_dir_untouched: assert property (@(posedge hclk) disable iff (!hresetn)
        !(cmd_go && op == op_port_direction_load)
        |=> $stable(dir_r))
        else $error("direction register changed without a load");

    a_no_op_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_none
        |=> $stable(flags_r) && $stable(result_r) && $stable(acc_r) && $stable(freg_r))
        else $error("empty command changed state");

    a_read_data_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        !(addr_phase && !hwrite)
        |=> hrdata == 32'h00000000)
        else $error("read data left standing outside a data phase");

    a_zero_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(hresetn) |-> hreadyout)
        else $error("ready low outside reset");

    c_sub_zero: cover property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_sub_acc_from_reg ##1 zero_out && carry_out);
    c_sub_borrow: cover property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_sub_acc_from_reg ##1 !carry_out);
    c_dir_loaded: cover property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_port_direction_load && faddr == dir_sel_ok);
    c_rotate_file: cover property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_rotate_left_thru_carry && dest == dest_file);
    c_xor_zero: cover property (@(posedge hclk) disable iff (!hresetn)
        cmd_go && op == op_xor_acc_with_reg ##1 zero_out);

endmodule : byte_alu

// ### sim/core_bus_master.sv
// ahb-lite master standing in for the core that feeds the alu slice
`timescale 1ns/1ps
module core_bus_master (
    // clock and slave answer
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // request
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    import byte_alu_pkg::*;

    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // hready is sampled at the edge itself, before that edge's updates land
    task automatic wait_ready();
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask : wait_ready

    // one single word transfer; enter only right after a rising edge
    task automatic transfer(input logic [31:0] addr, input logic wr, input logic [31:0] wdata,
                            output logic [31:0] rdata);
        hsel   <= 1'b1;
        haddr  <= addr;
        htrans <= htrans_nonseq;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wr ? wdata : ~hwdata;
        wait_ready();
        rdata = hrdata;
        // released data lines must not keep looking valid
        hwdata <= ~hwdata;
    endtask : transfer
endmodule : core_bus_master

// ### sim/byte_alu_bench.sv
// self-checking bench for the byte alu slice
`timescale 1ns/1ps
module byte_alu_bench;
    import byte_alu_pkg::*;

    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  freg;
        logic [2:0]  st;
        logic [23:0] cmd;
        logic [7:0]  e_acc;
        logic [7:0]  e_freg;
        logic [2:0]  e_st;
        logic [7:0]  e_dir;
    } row_type;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  acc_out;
    logic [7:0]  freg_out;
    logic [7:0]  dir_out;
    logic        carry_out;
    logic        half_carry_out;
    logic        zero_out;
    int          mismatches;
    int          samples_checked;
    int          cycles;
    row_type     tbl [16];

    byte_alu u_byte_alu (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .acc_out(acc_out), .freg_out(freg_out), .dir_out(dir_out),
        .carry_out(carry_out), .half_carry_out(half_carry_out), .zero_out(zero_out));

    core_bus_master u_core_bus_master (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    always #4 hclk = ~hclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask : check

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        u_core_bus_master.transfer({24'h0, addr}, 1'b1, data, unused);
    endtask : wr

    task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] got;
        u_core_bus_master.transfer({24'h0, addr}, 1'b0, 32'h0, got);
        check(got, exp);
    endtask : rd

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // 16 cycles a row; generous ceiling
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial begin
        hclk            = 1'b0;
        hresetn         = 1'b0;
        mismatches      = 0;
        samples_checked = 0;
        cycles          = 0;
        // acc, freg, status, command, then expected acc, freg, status, direction
        tbl = '{'{8'h05, 8'h03, 3'h0, 24'h000001, 8'hfe, 8'h03, 3'h0, 8'hff},
                '{8'h20, 8'h20, 3'h0, 24'h000009, 8'h20, 8'h00, 3'h7, 8'hff},
                '{8'h01, 8'h10, 3'h0, 24'h000001, 8'h0f, 8'h10, 3'h1, 8'hff},
                '{8'h00, 8'h81, 3'h6, 24'h00000a, 8'h00, 8'h02, 3'h7, 8'hff},
                '{8'h00, 8'h40, 3'h1, 24'h000002, 8'h81, 8'h40, 3'h0, 8'hff},
                '{8'h00, 8'h01, 3'h1, 24'h000003, 8'h80, 8'h01, 3'h1, 8'hff},
                '{8'h00, 8'h80, 3'h6, 24'h00000b, 8'h00, 8'h40, 3'h6, 8'hff},
                '{8'h00, 8'ha5, 3'h5, 24'h000004, 8'h5a, 8'ha5, 3'h5, 8'hff},
                '{8'h11, 8'h3c, 3'h2, 24'h00000c, 8'h11, 8'hc3, 3'h2, 8'hff},
                '{8'h5a, 8'h00, 3'h3, 24'h5a000e, 8'h00, 8'h00, 3'h7, 8'hff},
                '{8'h0f, 8'h00, 3'h4, 24'hf00006, 8'hff, 8'h00, 3'h0, 8'hff},
                '{8'h0f, 8'hf0, 3'h4, 24'h00000f, 8'h0f, 8'hff, 3'h0, 8'hff},
                '{8'h33, 8'h33, 3'h1, 24'h000007, 8'h00, 8'h33, 3'h5, 8'hff},
                '{8'h3c, 8'h00, 3'h7, 24'h000605, 8'h3c, 8'h00, 3'h7, 8'h3c},
                '{8'h11, 8'h00, 3'h7, 24'h000705, 8'h11, 8'h00, 3'h7, 8'h3c},
                '{8'h12, 8'h34, 3'h2, 24'h000008, 8'h12, 8'h34, 3'h2, 8'h3c}};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(acc_offset, 32'h0);
        rd(status_offset, 32'h0);
        rd(dir_offset, 32'hff);
        rd(freg_offset, {24'h0, freg_reset});
        rd(cmd_offset, 32'h0);
        rd(result_offset, {24'h0, result_reset});
        check({5'h0, zero_out, half_carry_out, carry_out, dir_out, freg_out, acc_out},
              {5'h0, flags_reset, dir_reset, freg_reset, acc_reset});
        $display("test reset done");
        // each row loads operands, runs one command, reads back acc, freg, status and direction
        for (int i = 0; i < 16; i++) begin
            wr(acc_offset, {24'h0, tbl[i].acc});
            wr(freg_offset, {24'h0, tbl[i].freg});
            wr(status_offset, {29'h0, tbl[i].st});
            wr(cmd_offset, {8'h0, tbl[i].cmd});
            rd(acc_offset, {24'h0, tbl[i].e_acc});
            rd(freg_offset, {24'h0, tbl[i].e_freg});
            rd(status_offset, {29'h0, tbl[i].e_st});
            rd(dir_offset, {24'h0, tbl[i].e_dir});
            check({5'h0, zero_out, half_carry_out, carry_out, dir_out, freg_out, acc_out},
                  {5'h0, tbl[i].e_st, tbl[i].e_dir, tbl[i].e_freg, tbl[i].e_acc});
            $display("test row %0d done", i);
        end
        // direction register is read-only from the bus; unmapped space reads zero
        wr(dir_offset, 32'h0);
        rd(dir_offset, 32'h3c);
        check({24'h0, dir_out}, 32'h3c);
        rd(8'h18, 32'h0);
        check({31'h0, hresp}, {31'h0, hresp_okay});
        check({31'h0, hreadyout}, 32'h1);
        $display("test bus edges done");
        // literal reaching the top command bits, then the stored command and result
        wr(cmd_offset, 32'h00e10006);
        rd(result_offset, 32'hf3);
        rd(acc_offset, 32'hf3);
        rd(status_offset, 32'h2);
        rd(cmd_offset, 32'h00e10006);
        $display("test command readback done");
        // second reset in mid-run; the bus is idle while it is held
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        check({31'h0, hreadyout}, 32'h0);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(acc_offset, {24'h0, acc_reset});
        rd(dir_offset, {24'h0, dir_reset});
        rd(cmd_offset, 32'h0);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule : byte_alu_bench
